//--- inc/urb_map.vh
// register offsets, reset values and field positions of the receive buffer pointer block
`ifndef URB_MAP_VH
`define URB_MAP_VH
`define URB_RD_IDX_OFS 8'h96
`define URB_WR_IDX_OFS 8'h98
`define URB_NXT_IDX_OFS 8'h9a
`define URB_FREE_OFS 8'h9c
`define URB_FLAGS_OFS 8'h9e
`define URB_LDQ_OFS 8'hb0
`define URB_RD_MSG_OFS 8'h90
`define URB_RD_NXT_MSG_OFS 8'h92
`define URB_RD_IDX_RST 7'h00
`define URB_WR_IDX_RST 7'h01
`define URB_NXT_IDX_RST 7'h00
`define URB_FREE_RST 7'h56
`define URB_FLAG_LAST 0
`define URB_FLAG_ERR 1
`define URB_FLAG_FIRST 2
`endif

//--- core/urb_rx_buffer.v
// receive buffer storage with read, write and next-message index logic
//
// How it works
// - seven-bit read index names the next location the host reads; read only
// - read index advances by itself after each buffer byte is read, except after a last byte or the newest stored byte
// - read index clears to zero on reset
// - seven-bit write index advances as each received byte is stored
// - write index resets to one and reads back read only
// - free byte count reports remaining space, 0x56 after reset
// - flag bit 2 marks first data byte of a message at read index
// - flag bit 0 marks last byte; stop character stored as null byte
`timescale 1ns/1ps
`include "urb_map.vh"

module urb_rx_buffer #(
  parameter DEPTH = 128,
  parameter FREE_INIT = 7'h56
) (
  input wire sys_clk, // system clock
  input wire rst, // synchronous reset, active high
  input wire rx_wr_valid, // receiver offers a byte
  input wire [7:0] rx_wr_data, // received byte
  input wire rx_wr_first, // byte follows the preamble
  input wire rx_wr_err, // character had a coding error
  input wire rx_wr_stop, // character was a stop character
  output wire rx_wr_ready, // buffer has room
  input wire reg_rd, // host register read strobe
  input wire reg_wr, // host register write strobe
  input wire [7:0] reg_addr, // register address
  input wire [7:0] reg_wdata, // register write data
  output reg [7:0] reg_rdata, // register read data, registered
  output reg reg_rvalid, // read data valid pulse
  output wire advance_load_queue // one-cycle pulse to the load queue
);

  localparam [31:0] LAST_LOC = DEPTH - 1;
  localparam [31:0] DEPTH32 = DEPTH;
  localparam [7:0] DEPTH8 = DEPTH32[7:0];
  localparam [6:0] RD_IDX_RST = `URB_RD_IDX_RST;
  localparam [6:0] WR_IDX_RST = `URB_WR_IDX_RST;
  localparam [6:0] NXT_IDX_RST = `URB_NXT_IDX_RST;
  localparam [2:0] FLAGS_RST = 3'h0;
  localparam [7:0] LDQ_RST = 8'h00;
  localparam [1:0] OP_HOLD = 2'h0;
  localparam [1:0] OP_STEP = 2'h1;
  localparam [1:0] OP_JUMP = 2'h2;
  localparam [1:0] OP_JUMP_STEP = 2'h3;

  // received bytes; a stop character is kept as a null byte
  reg [7:0] mem_q [0:DEPTH-1];
  // per-byte flags {first, err, last}, one flop group per location so reset clears them
  wire [2:0] flg_w [0:DEPTH-1];

  reg [6:0] rx_read_index_q;
  reg [6:0] rx_read_index_d;
  reg [6:0] rx_write_index_q;
  reg [6:0] rx_write_index_d;
  reg [6:0] rx_next_message_index_q;
  reg [6:0] rx_next_message_index_d;
  reg [6:0] free_q;
  reg [6:0] free_d;
  reg [6:0] used_d;
  reg [7:0] ldq_q;
  reg ldq_pulse_q;
  reg [7:0] rdata_d;
  reg store;
  reg rd_msg;
  reg rd_nxt;
  reg ldq_wr;
  reg step_msg;
  reg step_nxt;
  reg [1:0] rd_op;
  wire [2:0] cur_flags;
  wire [2:0] nxt_flags;
  wire [7:0] view_rd_idx;
  wire [7:0] view_wr_idx;
  wire [7:0] view_nxt_idx;
  wire [7:0] view_free;
  wire [7:0] view_flags;

  // next location, wrapping at the end of the buffer
  function [6:0] inc7;
    input [6:0] v;
    begin
      if ({25'h0, v} == LAST_LOC) begin
        inc7 = 7'h00;
      end else begin
        inc7 = v + 7'h01;
      end
    end
  endfunction

  // bytes held strictly between the read index and the write index;
  // the location under the read index is kept out of the free count
  function [6:0] held;
    input [6:0] rd;
    input [6:0] wr;
    reg [7:0] span;
    begin
      if (wr > rd) begin
        span = {1'b0, wr} - {1'b0, rd};
      end else begin
        span = DEPTH8 - {1'b0, rd} + {1'b0, wr};
      end
      held = span[6:0] - 7'h01;
    end
  endfunction

  // address match, shared by every strobe decode
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  assign cur_flags = flg_w[rx_read_index_q];
  assign nxt_flags = flg_w[rx_next_message_index_q];
  assign view_rd_idx = {1'b0, rx_read_index_q};
  assign view_wr_idx = {1'b0, rx_write_index_q};
  assign view_nxt_idx = {1'b0, rx_next_message_index_q};
  assign view_free = {1'b0, free_q};
  assign view_flags = {5'h00, cur_flags};
  assign rx_wr_ready = (free_q != 7'h00);
  assign advance_load_queue = ldq_pulse_q;

  // a read never steps past the newest stored byte nor into the next message
  always @* begin
    store = rx_wr_valid && rx_wr_ready;
    rd_msg = reg_rd && hit(reg_addr, `URB_RD_MSG_OFS);
    rd_nxt = reg_rd && hit(reg_addr, `URB_RD_NXT_MSG_OFS);
    ldq_wr = reg_wr && hit(reg_addr, `URB_LDQ_OFS);
    step_msg = rd_msg && !cur_flags[`URB_FLAG_LAST]
               && (inc7(rx_read_index_q) != rx_write_index_q);
    step_nxt = rd_nxt && !nxt_flags[`URB_FLAG_LAST]
               && (inc7(rx_next_message_index_q) != rx_write_index_q);
    if (rd_nxt) begin
      rd_op = step_nxt ? OP_JUMP_STEP : OP_JUMP;
    end else if (step_msg) begin
      rd_op = OP_STEP;
    end else begin
      rd_op = OP_HOLD;
    end
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : gen_flag
      reg [2:0] flag_q;
      always @(posedge sys_clk) begin
        if (rst) begin
          flag_q <= FLAGS_RST;
        end else if (store && ({25'h0, rx_write_index_q} == g)) begin
          flag_q <= {rx_wr_first, rx_wr_err, rx_wr_stop};
        end
      end
      assign flg_w[g] = flag_q;
    end
  endgenerate

  always @(posedge sys_clk) begin
    if (store) begin
      mem_q[rx_write_index_q] <= rx_wr_stop ? 8'h00 : rx_wr_data;
    end
  end

  always @* begin
    rx_write_index_d = rx_write_index_q;
    if (store) begin
      rx_write_index_d = inc7(rx_write_index_q);
    end
  end

  // a jump lands on the message start, then steps like a plain message read
  always @* begin
    rx_read_index_d = rx_read_index_q;
    case (rd_op)
      OP_STEP: begin
        rx_read_index_d = inc7(rx_read_index_q);
      end
      OP_JUMP: begin
        rx_read_index_d = rx_next_message_index_q;
      end
      OP_JUMP_STEP: begin
        rx_read_index_d = inc7(rx_next_message_index_q);
      end
      default: begin
        rx_read_index_d = rx_read_index_q;
      end
    endcase
  end

  // reading a last byte marks where the next unread message starts
  always @* begin
    rx_next_message_index_d = rx_next_message_index_q;
    if (rd_nxt && nxt_flags[`URB_FLAG_LAST]) begin
      rx_next_message_index_d = inc7(rx_next_message_index_q);
    end else if (rd_msg && cur_flags[`URB_FLAG_LAST]) begin
      rx_next_message_index_d = inc7(rx_read_index_q);
    end
  end

  // free space follows the indices, so a jump by read-next-message frees skipped bytes
  always @* begin
    used_d = held(rx_read_index_d, rx_write_index_d);
    free_d = FREE_INIT - used_d;
  end

  // every read answers one cycle later; unmapped addresses read as zero
  always @* begin
    rdata_d = 8'h00;
    case (reg_addr)
      `URB_RD_IDX_OFS: rdata_d = view_rd_idx;
      `URB_WR_IDX_OFS: rdata_d = view_wr_idx;
      `URB_NXT_IDX_OFS: rdata_d = view_nxt_idx;
      `URB_FREE_OFS: rdata_d = view_free;
      `URB_FLAGS_OFS: rdata_d = view_flags;
      `URB_LDQ_OFS: rdata_d = ldq_q;
      `URB_RD_MSG_OFS: rdata_d = mem_q[rx_read_index_q];
      `URB_RD_NXT_MSG_OFS: rdata_d = mem_q[rx_next_message_index_q];
      default: rdata_d = 8'h00;
    endcase
  end

  // read index moves only by the host's own reads
  always @(posedge sys_clk) begin
    if (rst) begin
      rx_read_index_q <= RD_IDX_RST;
    end else begin
      rx_read_index_q <= rx_read_index_d;
    end
  end

  // write index starts one ahead of the read index
  always @(posedge sys_clk) begin
    if (rst) begin
      rx_write_index_q <= WR_IDX_RST;
    end else begin
      rx_write_index_q <= rx_write_index_d;
    end
  end

  // oldest unread message start
  always @(posedge sys_clk) begin
    if (rst) begin
      rx_next_message_index_q <= NXT_IDX_RST;
    end else begin
      rx_next_message_index_q <= rx_next_message_index_d;
    end
  end

  // free count is registered so the host sees a stable value per read
  always @(posedge sys_clk) begin
    if (rst) begin
      free_q <= FREE_INIT;
    end else begin
      free_q <= free_d;
    end
  end

  // read data is launched from a flop, one cycle after the strobe
  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // read valid follows the strobe by one cycle
  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // the load queue register keeps the last value written; the pulse is what matters
  always @(posedge sys_clk) begin
    if (rst) begin
      ldq_q <= LDQ_RST;
    end else if (ldq_wr) begin
      ldq_q <= reg_wdata;
    end
  end

  // one pulse per write, even when the same value is written again
  always @(posedge sys_clk) begin
    if (rst) begin
      ldq_pulse_q <= 1'b0;
    end else begin
      ldq_pulse_q <= ldq_wr;
    end
  end

endmodule // urb_rx_buffer

//--- testbench/urb_rx_src.sv
// receiver-side model: offers the bench's byte one cycle after go
`timescale 1ns/1ps
module urb_rx_src (
  input wire clk, input wire go, input wire [10:0] b, // clock, offer, {first,err,stop,byte}
  output reg v = 1'b0, output reg [10:0] o = 11'h000 // offered flags and byte, copied unchanged from b
);
  always @(posedge clk) v <= go;
  always @(posedge clk) o <= b;
endmodule // urb_rx_src

//--- testbench/urb_rx_buffer_checker.sv
// assertions on the register side of the receive buffer pointer block
`timescale 1ns/1ps
module urb_rx_buffer_checker (
  input wire sys_clk, input wire rst, input wire reg_rd, input wire reg_wr, // strobes
  input wire [7:0] reg_addr, input wire [7:0] reg_rdata, // address and data
  input wire reg_rvalid, input wire advance_load_queue // answers
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  rd_ans_a: assert property (reg_rd |=> reg_rvalid) else $error("no rvalid");
  rv_cause_a: assert property ($rose(reg_rvalid) |-> $past(reg_rd)) else $error("stray rvalid");
  rv_once_a: assert property (!reg_rd |=> !reg_rvalid) else $error("rvalid held");
  ldq_on_a: assert property (reg_wr && reg_addr == 8'hb0 |=> advance_load_queue) else $error("no pulse");
  ldq_off_a: assert property (!reg_wr |=> !advance_load_queue) else $error("stray pulse");
  idx_msb_a: assert property (reg_rd && reg_addr inside {8'h96, 8'h98, 8'h9a, 8'h9c}
    |=> !reg_rdata[7]) else $error("index bit 7 set");
  flag_top_a: assert property (reg_rd && reg_addr == 8'h9e |=> reg_rdata[7:3] == 5'h00)
    else $error("flag spare bits");
  unmap_a: assert property (reg_rd && reg_addr == 8'ha0 |=> reg_rdata == 8'h00) else $error("unmapped");
endmodule // urb_rx_buffer_checker
bind urb_rx_buffer urb_rx_buffer_checker chk (.sys_clk, .rst, .reg_rd, .reg_wr, .reg_addr,
  .reg_rdata, .reg_rvalid, .advance_load_queue);

//--- testbench/uart_receive_buffer_pointers_test.sv
// self-checking bench for the receive buffer pointer block
`timescale 1ns/1ps
module uart_receive_buffer_pointers_test;
  reg sys_clk = 0, rst = 1, reg_rd = 0, reg_wr = 0, go = 0;
  reg [7:0] reg_addr = 8'h00;
  reg [10:0] b = 11'h000;
  wire [10:0] o;
  wire [7:0] rdata;
  wire v;
  integer failures = 0, total_checks = 0, i;
  urb_rx_buffer dut (.sys_clk, .rst, .rx_wr_valid(v), .rx_wr_data(o[7:0]), .rx_wr_first(o[10]),
    .rx_wr_err(o[9]), .rx_wr_stop(o[8]), .rx_wr_ready(), .reg_rd, .reg_wr, .reg_addr,
    .reg_wdata(8'h00), .reg_rdata(rdata), .reg_rvalid(), .advance_load_queue());
  urb_rx_src src (.clk(sys_clk), .go, .b, .v, .o);
  initial forever #2 sys_clk = ~sys_clk;
  task ck(input [7:0] s, x);
    total_checks++;
    if (s !== x) $display("Error rdata expected %h seen %h", x, s);
    if (s !== x) failures++;
  endtask
  task rd(input [7:0] a, x, input m = 1'b1);
    @(posedge sys_clk) reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 if (m) ck(rdata, x);
  endtask
  task close_out(input integer late);
    failures += late;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // a hang is cut after about 5000 cycles, far beyond the sequence
  initial #20000 close_out(1);
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) rd(8'h96 + 2 * i, i == 1 ? 8'h01 : i == 3 ? 8'h56 : 8'h00);
    @(posedge sys_clk) go <= 1'b1;
    b <= 11'h45a;
    @(posedge sys_clk) b <= 11'h300;
    @(posedge sys_clk) go <= 1'b0;
    rd(8'h98, 8'h03);
    rd(8'h90, 8'h00, 1'b0);
    rd(8'h96, 8'h01);
    rd(8'h9e, 8'h04);
    rd(8'h90, 8'h5a);
    rd(8'h9e, 8'h03);
    rd(8'h90, 8'h00);
    rd(8'h9c, 8'h56);
    @(posedge sys_clk) go <= 1'b1;
    b <= 11'h433;
    @(posedge sys_clk) go <= 1'b0;
    rd(8'h92, 8'h33);
    rd(8'h96, 8'h03);
    rd(8'h9c, 8'h56);
    @(posedge sys_clk) reg_wr <= 1'b1;
    reg_addr <= 8'hb0;
    @(posedge sys_clk) reg_wr <= 1'b0;
    close_out(0);
  end
endmodule // uart_receive_buffer_pointers_test
